// File: hdl/tws_pkg.sv
// Shared constants and types of the two-wire slave port.
// Assumes a 32-bit classic Wishbone register bus and one system clock.
package tws_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_SETTINGS = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_BUFFER = 5'h08;
  localparam logic [4:0] OFS_OWN_ADDR = 5'h0C;
  localparam logic [4:0] OFS_TIMEOUT = 5'h10;
  localparam logic [4:0] OFS_PULL = 5'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_IFACE_ON = 1;
  localparam int BIT_FILT_LO = 2;
  localparam int BIT_FILT_HI = 3;
  localparam int BIT_PULL_SCL = 0;
  localparam int BIT_PULL_SDA = 1;
  localparam int BIT_OWN_ADDR_LO = 1;
  localparam logic [7:0] RST_SETTINGS = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h81;
  localparam logic [7:0] RST_OWN_ADDR = 8'h00;
  localparam logic [7:0] RST_TIMEOUT = 8'h00;
  localparam logic [7:0] RST_PULL = 8'h00;

  // ----------------------------------------------------------------
  // Debounce codes and lengths
  // ----------------------------------------------------------------
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_SHORT_CODE = 2'h1;
  localparam logic [2:0] FILT_SHORT_LEN = 3'h2;
  localparam logic [2:0] FILT_LONG_LEN = 3'h4;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Status and control byte, msb first
  typedef struct packed {
    logic byte_done_flag;
    logic addr_match_flag;
    logic bus_busy_flag;
    logic transmit_select;
    logic ack_out_bit;
    logic master_dir_flag;
    logic match_wake_enable;
    logic ack_in_flag;
  } tws_status_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ADDR_ACK = 8'h04,
    ST_HOLD = 8'h08,
    ST_RX = 8'h10,
    ST_RX_ACK = 8'h20,
    ST_TX = 8'h40,
    ST_TX_ACK = 8'h80
  } tws_state_t;

  function automatic logic [2:0] tws_filter_len(input logic [1:0] sel);
    if (sel == FILT_NONE)
    begin
      return 3'h0;
    end
    else if (sel == FILT_SHORT_CODE)
    begin
      return FILT_SHORT_LEN;
    end
    return FILT_LONG_LEN;
  endfunction : tws_filter_len

endpackage : tws_pkg

// File: hdl/tws_port.sv
// Slave-only two-wire serial port with Wishbone register access.
// Assumes open-drain lines resolved outside; pins are asynchronous to clk.
//
// Contract
// - Selected debounce filters bus inputs for 2 or 4 system clocks.
// - Filter code 00 none, 01 two clocks, 10 and 11 four clocks.
// - Every byte passes one 8-bit buffer; software loads or reads it. The address byte is not loaded into it here.
// - Own address sits in bits 7..1, resets zero, bit 0 reads zero.
// - Slave is selected only when received address equals own address.
// - With the interface off the pins are not bus lines.
// - Enabling keeps transmit-select and ack-out, resets the other flags; the code keeps wake-enable as well.
// - Byte-done reads 0 during a byte, 1 after eight received bits or after the ack clock of a sent byte.
// - Reading the buffer clears byte-done.
// - Start clears byte-done; stop sets it.
// - Address-match flag is high on a matching address, else low.
// - Busy flag sets on start and clears on stop.
// - Transmit-select 0 makes a receiver, 1 a transmitter.
// - Ack-out bit is driven on the 9th clock after a received byte.
// - Direction flag holds the received read/write bit.
// - With wake enabled, a matching address requests wake-up.
// - Ack-in flag takes the master acknowledge; it resets to 1.
// - Transmitter releases data line when no acknowledge comes.
// - Pins are open-drain with software pull-high enables.
// - Address arrives MSB first, 8th bit is direction, ack on match.
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
module tws_port
  import tws_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Bus clock line
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  output logic scl_pullup_en,
  // Bus data line
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic sda_pullup_en,
  // System side
  output logic iface_active,
  output logic byte_event,
  output logic wake_req
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic bus_req;
  logic wr_en;
  logic rd_buf;
  logic wr_buf;
  logic buf_access;
  logic [1:0] filt_sel;
  logic [7:0] own_addr;
  logic [7:0] timeout_setup;
  logic [7:0] byte_buffer;
  tws_status_t status;
  logic [7:0] rd_data;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
  assign rd_buf = bus_req & ~wb_we_i & (wb_adr_i == OFS_BUFFER);
  assign wr_buf = wr_en & (wb_adr_i == OFS_BUFFER);
  assign buf_access = rd_buf | wr_buf;

  always_comb
  begin
    unique case (wb_adr_i)
      OFS_SETTINGS: rd_data = {4'h0, filt_sel, iface_active, 1'b0};
      OFS_STATUS: rd_data = status;
      OFS_BUFFER: rd_data = byte_buffer;
      OFS_OWN_ADDR: rd_data = {own_addr[7:1], 1'b0};
      OFS_TIMEOUT: rd_data = timeout_setup;
      OFS_PULL: rd_data = {6'h00, sda_pullup_en, scl_pullup_en};
      default: rd_data = 8'h00;
    endcase
  end

  // One wait state; unmapped addresses answer with zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req & ~wb_we_i) ? {24'h00_0000, rd_data} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      filt_sel <= RST_SETTINGS[BIT_FILT_HI:BIT_FILT_LO];
      iface_active <= RST_SETTINGS[BIT_IFACE_ON];
      own_addr <= RST_OWN_ADDR;
      timeout_setup <= RST_TIMEOUT;
      scl_pullup_en <= RST_PULL[BIT_PULL_SCL];
      sda_pullup_en <= RST_PULL[BIT_PULL_SDA];
    end
    else if (wr_en)
    begin
      unique case (wb_adr_i)
        OFS_SETTINGS:
        begin
          filt_sel <= wb_dat_i[BIT_FILT_HI:BIT_FILT_LO];
          iface_active <= wb_dat_i[BIT_IFACE_ON];
        end
        OFS_OWN_ADDR: own_addr <= {wb_dat_i[7:BIT_OWN_ADDR_LO], 1'b0};
        OFS_TIMEOUT: timeout_setup <= wb_dat_i[7:0];
        OFS_PULL:
        begin
          scl_pullup_en <= wb_dat_i[BIT_PULL_SCL];
          sda_pullup_en <= wb_dat_i[BIT_PULL_SDA];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and debounce
  // ----------------------------------------------------------------
  // Index 0 is the clock line, index 1 the data line
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] filt;
  logic [1:0] filt_d;
  logic [2:0] fcnt [2];
  logic [2:0] flen;

  assign flen = tws_filter_len(filt_sel);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_meta <= 2'h3;
      pin_sync <= 2'h3;
    end
    else
    begin
      pin_meta <= {sda_i, scl_i};
      pin_sync <= pin_meta;
    end
  end

  // A change is taken only after it stood flen samples in a row
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      filt <= 2'h3;
      filt_d <= 2'h3;
      fcnt[0] <= 3'h0;
      fcnt[1] <= 3'h0;
    end
    else
    begin
      filt_d <= filt;
      for (int i = 0; i < 2; i++)
      begin
        if (flen == 3'h0 || pin_sync[i] == filt[i])
        begin
          filt[i] <= pin_sync[i];
          fcnt[i] <= 3'h0;
        end
        else if (fcnt[i] + 3'h1 >= flen)
        begin
          filt[i] <= pin_sync[i];
          fcnt[i] <= 3'h0;
        end
        else
        begin
          fcnt[i] <= fcnt[i] + 3'h1;
        end
      end
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = filt[0] & ~filt_d[0];
  assign scl_fall = ~filt[0] & filt_d[0];
  assign start_det = iface_active & filt[0] & filt_d[0] & ~filt[1] & filt_d[1];
  assign stop_det = iface_active & filt[0] & filt_d[0] & filt[1] & ~filt_d[1];

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  tws_state_t state;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx_byte;
  logic addr_done;
  logic addr_hit;
  logic rx_done;
  logic tx_ack_seen;
  logic done_set;

  assign addr_done = (state == ST_ADDR) & scl_rise & (bit_cnt == LAST_BIT);
  assign addr_hit = addr_done & (shreg[6:0] == own_addr[7:1]);
  assign rx_done = (state == ST_RX) & scl_rise & (bit_cnt == LAST_BIT);
  assign tx_ack_seen = (state == ST_TX_ACK) & scl_rise;
  assign done_set = addr_hit | rx_done | tx_ack_seen;
  // Software write in the release cycle goes straight to the shifter
  assign tx_byte = wr_buf ? wb_dat_i[7:0] : byte_buffer;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end
    else if (!iface_active)
    begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end
    else if (start_det)
    begin
      state <= ST_ADDR;
      bit_cnt <= 3'h0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end
    else if (stop_det)
    begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE: ;
        ST_ADDR, ST_RX:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], filt[1]};
            bit_cnt <= bit_cnt + 3'h1;
            if (addr_done)
            begin
              state <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
            end
            if (rx_done)
            begin
              state <= ST_RX_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_RX_ACK:
        begin
          if (scl_fall && bit_cnt == 3'h0)
          begin
            sda_oe <= (state == ST_ADDR_ACK) | ~status.ack_out_bit;
            bit_cnt <= 3'h1;
          end
          else if (scl_fall)
          begin
            sda_oe <= 1'b0;
            // A refused byte ends the exchange without stretching
            if (state == ST_ADDR_ACK || !status.ack_out_bit)
            begin
              scl_oe <= 1'b1;
              state <= ST_HOLD;
            end
            else
            begin
              state <= ST_IDLE;
            end
          end
        end
        ST_HOLD:
        begin
          if (buf_access)
          begin
            scl_oe <= 1'b0;
            bit_cnt <= 3'h0;
            if (status.transmit_select)
            begin
              shreg <= tx_byte;
              sda_oe <= ~tx_byte[7];
              state <= ST_TX;
            end
            else
            begin
              state <= ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == LAST_BIT)
            begin
              sda_oe <= 1'b0;
              state <= ST_TX_ACK;
            end
            else
            begin
              sda_oe <= ~shreg[6];
              shreg <= {shreg[6:0], 1'b0};
            end
          end
        end
        ST_TX_ACK:
        begin
          if (scl_fall)
          begin
            if (!status.ack_in_flag)
            begin
              scl_oe <= 1'b1;
              state <= ST_HOLD;
            end
            else
            begin
              sda_oe <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Lines only ever pull low
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // Buffer keeps no reset value; software must load it before use
  always_ff @(posedge clk)
  begin
    if (rx_done)
    begin
      byte_buffer <= {shreg[6:0], filt[1]};
    end
    else if (wr_buf)
    begin
      byte_buffer <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status <= RST_STATUS;
    end
    else
    begin
      if (wr_en && wb_adr_i == OFS_STATUS)
      begin
        status.transmit_select <= wb_dat_i[4];
        status.ack_out_bit <= wb_dat_i[3];
        status.match_wake_enable <= wb_dat_i[1];
      end
      if (!iface_active)
      begin
        status.byte_done_flag <= RST_STATUS[7];
        status.addr_match_flag <= RST_STATUS[6];
        status.bus_busy_flag <= RST_STATUS[5];
        status.master_dir_flag <= RST_STATUS[2];
        status.ack_in_flag <= RST_STATUS[0];
      end
      else
      begin
        if (start_det)
        begin
          status.bus_busy_flag <= 1'b1;
        end
        else if (stop_det)
        begin
          status.bus_busy_flag <= 1'b0;
        end
        // Clear first so a same-cycle set wins
        if (start_det || rd_buf || (wr_buf && state == ST_HOLD))
        begin
          status.byte_done_flag <= 1'b0;
        end
        if (done_set || stop_det)
        begin
          status.byte_done_flag <= 1'b1;
        end
        if (start_det || stop_det || rx_done || tx_ack_seen)
        begin
          status.addr_match_flag <= 1'b0;
        end
        if (addr_hit)
        begin
          status.addr_match_flag <= 1'b1;
          status.master_dir_flag <= filt[1];
        end
        if (tx_ack_seen)
        begin
          status.ack_in_flag <= filt[1];
        end
      end
    end
  end

  // Event and wake pulses toward the system
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      byte_event <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      byte_event <= done_set;
      wake_req <= addr_hit & status.match_wake_enable;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence addr_hit_s;
    addr_hit ##1 status.addr_match_flag;
  endsequence

  sequence ack_drive_s;
    (state == ST_RX_ACK) && scl_fall && bit_cnt == 3'h0 && !start_det && !stop_det;
  endsequence

  filt_short_a: assert property (
    filt_sel == FILT_SHORT_CODE && $changed(filt[0])
    |-> $past(pin_sync[0], 1) == filt[0] && $past(pin_sync[0], 2) == filt[0])
    else $error("short filter passed a glitch");
  filt_long_a: assert property (
    filt_sel[1] && $changed(filt[0]) && $stable(filt_sel) |->
    $past(pin_sync[0], 1) == filt[0] && $past(pin_sync[0], 4) == filt[0])
    else $error("long filter passed a glitch");
  bus_off_a: assert property (
    !iface_active |=> !scl_oe && !sda_oe)
    else $error("pins driven while disabled");
  enable_rise_a: assert property (
    $rose(iface_active) |-> status.byte_done_flag && !status.addr_match_flag
    && !status.bus_busy_flag && status.ack_in_flag)
    else $error("flags not at defaults on enable");
  read_clear_a: assert property (
    rd_buf && iface_active && !done_set && !stop_det |=> !status.byte_done_flag)
    else $error("buffer read kept byte done");
  start_busy_a: assert property (
    start_det |=> status.bus_busy_flag && !status.byte_done_flag)
    else $error("start not seen in flags");
  stop_free_a: assert property (
    stop_det |=> !status.bus_busy_flag && status.byte_done_flag)
    else $error("stop not seen in flags");
  addr_match_a: assert property (
    addr_hit |-> addr_hit_s)
    else $error("address match flag missing");
  ack_drive_a: assert property (
    ack_drive_s |=> sda_oe == !status.ack_out_bit)
    else $error("ack out not driven");
  nack_release_a: assert property (
    (state == ST_TX_ACK) && scl_fall && status.ack_in_flag && iface_active
    |=> !sda_oe && !scl_oe)
    else $error("data line held after no ack");
  stretch_hold_a: assert property (
    state == ST_HOLD && !buf_access && iface_active && !start_det && !stop_det
    |=> scl_oe && state == ST_HOLD)
    else $error("clock released without access");

endmodule : tws_port

// File: verification/tws_master_model.sv
// Bus master model that drives the far side of the two-wire slave port.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/100ps
module tws_master_model
(
  // Resolved lines
  input wire logic scl,
  input wire logic sda,
  // Pull-low drives
  output logic scl_low,
  output logic sda_low
);
  // Half period of the 160 ns link clock
  localparam int HALF = 80;
  // Clock waits that ran out; the bench adds them to its error count
  int stall_cnt;

  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // Bounded wait, the slave may stretch the clock
  task automatic wait_hi();
    int n;
    n = 0;
    while (scl !== 1'b1 && n < 5000)
    begin
      #10;
      n++;
    end
    if (n >= 5000)
      stall_cnt++;
  endtask : wait_hi

  // Data is sampled late in the high phase, after slave output settles
  task automatic bit_io(input logic b, output logic r);
    #(HALF/2) sda_low = ~b;
    #(HALF/2) scl_low = 1'b0;
    wait_hi();
    #(HALF-2) r = sda;
    #2 scl_low = 1'b1;
  endtask : bit_io

  task automatic start_c();
    sda_low = 1'b1;
    #HALF scl_low = 1'b1;
  endtask : start_c

  task automatic stop_c();
    #(HALF/2) sda_low = 1'b1;
    #(HALF/2) scl_low = 1'b0;
    wait_hi();
    #HALF sda_low = 1'b0;
    #(2*HALF);
  endtask : stop_c

  // Extra low time after the ack bit lets a stretch land before release
  task automatic xfer(input logic [7:0] wr, input logic ack_drv,
                      output logic [7:0] rd, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(wr[i], rd[i]);
    end
    bit_io(ack_drv, ack);
    #(2*HALF);
  endtask : xfer
endmodule : tws_master_model

// File: verification/tws_port_tb.sv
// Self-checking bench for the two-wire slave port.
// Assumes a master model on the lines and Wishbone register access here.
`timescale 1ns/100ps
module tws_port_tb
  import tws_pkg::*;
;
  logic clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_sel_i;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic scl_oe, sda_oe, scl_pullup_en, sda_pullup_en;
  logic iface_active, byte_event, wake_req, scl_low, sda_low, ack, scl_o, sda_o;
  logic [7:0] rd, d, w;
  wire logic scl_w;
  wire logic sda_w;
  int error_cnt, checks, wake_cnt, ev_cnt;

  // Open drain: an enabled driver pulls the line low only when its output is 0
  assign scl_w = ~scl_low & ~(scl_oe & ~scl_o);
  assign sda_w = ~sda_low & ~(sda_oe & ~sda_o);

  tws_port i_dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .scl_pullup_en(scl_pullup_en), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .sda_pullup_en(sda_pullup_en), .iface_active(iface_active), .byte_event(byte_event),
    .wake_req(wake_req));

  tws_master_model i_bfm (.scl(scl_w), .sda(sda_w), .scl_low(scl_low), .sda_low(sda_low));

  always @(posedge clk)
  begin
    if (wake_req === 1'b1)
      wake_cnt++;
    if (byte_event === 1'b1)
      ev_cnt++;
  end

  // ----------------------------------------------------------------
  // Register access and comparison
  // ----------------------------------------------------------------
  task automatic wb_xfer(input logic we, input logic [4:0] adr, input logic [7:0] wd,
                         output logic [7:0] rdat);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, wd};
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    if (wb_ack_o !== 1'b1)
      error_cnt++;
    rdat = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  task automatic wb_wr(input logic [4:0] adr, input logic [7:0] wd);
    logic [7:0] x;
    wb_xfer(1'b1, adr, wd, x);
  endtask : wb_wr

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [4:0] adr, input logic [7:0] exp);
    logic [7:0] x;
    wb_xfer(1'b0, adr, 8'h00, x);
    chk(x, exp);
  endtask : rd_chk

  task automatic summarize();
    error_cnt += i_bfm.stall_cnt;
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #400000;
    error_cnt++;
    summarize();
  end

  initial
  begin
    arst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_sel_i = 4'hF;
    wb_adr_i = 5'h00;
    wb_dat_i = 32'h0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(OFS_SETTINGS, RST_SETTINGS);
    rd_chk(OFS_STATUS, RST_STATUS);
    rd_chk(OFS_OWN_ADDR, RST_OWN_ADDR);
    rd_chk(OFS_PULL, RST_PULL);
    rd_chk(5'h18, 8'h00);
    wb_wr(OFS_OWN_ADDR, 8'hA5);
    rd_chk(OFS_OWN_ADDR, 8'hA4);
    wb_wr(OFS_PULL, 8'h01);
    chk({6'h0, sda_pullup_en, scl_pullup_en}, 8'h01);
    rd_chk(OFS_PULL, 8'h01);
    // Every filter code, wake enabled on the last pass
    for (int f = 0; f < 4; f++)
    begin
      w = (f == 3) ? 8'h02 : 8'h00;
      d = 8'h3C ^ 8'(f);
      wb_wr(OFS_STATUS, w);
      wb_wr(OFS_SETTINGS, {4'h0, f[1:0], 2'b10});
      rd_chk(OFS_SETTINGS, {4'h0, f[1:0], 2'b10});
      i_bfm.start_c();
      i_bfm.xfer(8'hA4, 1'b1, rd, ack);
      chk({7'h0, ack}, 8'h00);
      rd_chk(OFS_STATUS, 8'hE1 | w);
      wb_xfer(1'b0, OFS_BUFFER, 8'h00, rd);
      i_bfm.xfer(d, 1'b1, rd, ack);
      chk({7'h0, ack}, 8'h00);
      rd_chk(OFS_STATUS, 8'hA1 | w);
      rd_chk(OFS_BUFFER, d);
      rd_chk(OFS_STATUS, 8'h21 | w);
      i_bfm.stop_c();
      rd_chk(OFS_STATUS, 8'h81 | w);
    end
    wb_wr(OFS_STATUS, 8'h00);
    chk(8'(wake_cnt), 8'h01);
    i_bfm.start_c();
    i_bfm.xfer(8'hA6, 1'b1, rd, ack);
    chk({7'h0, ack}, 8'h01);
    rd_chk(OFS_STATUS, 8'h21);
    i_bfm.stop_c();
    // Master reads two bytes, acking the first only
    i_bfm.start_c();
    i_bfm.xfer(8'hA5, 1'b1, rd, ack);
    chk({7'h0, ack}, 8'h00);
    rd_chk(OFS_STATUS, 8'hE5);
    wb_wr(OFS_STATUS, 8'h10);
    wb_wr(OFS_BUFFER, 8'hC3);
    rd_chk(OFS_STATUS, 8'h75);
    i_bfm.xfer(8'hFF, 1'b0, rd, ack);
    chk(rd, 8'hC3);
    rd_chk(OFS_STATUS, 8'hB4);
    wb_wr(OFS_BUFFER, 8'h5A);
    i_bfm.xfer(8'hFF, 1'b1, rd, ack);
    chk(rd, 8'h5A);
    rd_chk(OFS_STATUS, 8'hB5);
    chk({6'h0, scl_oe, sda_oe}, 8'h00);
    i_bfm.stop_c();
    // Disabled port ignores the bus, enabling keeps control bits
    wb_wr(OFS_STATUS, 8'h18);
    wb_wr(OFS_SETTINGS, 8'h00);
    chk({7'h0, iface_active}, 8'h00);
    i_bfm.start_c();
    i_bfm.xfer(8'hA4, 1'b1, rd, ack);
    chk({7'h0, ack}, 8'h01);
    i_bfm.stop_c();
    wb_wr(OFS_SETTINGS, 8'h02);
    rd_chk(OFS_STATUS, 8'h99);
    // Receiver declines a byte with ack-out set
    wb_wr(OFS_STATUS, 8'h08);
    i_bfm.start_c();
    i_bfm.xfer(8'hA4, 1'b1, rd, ack);
    chk({7'h0, ack}, 8'h00);
    wb_xfer(1'b0, OFS_BUFFER, 8'h00, rd);
    i_bfm.xfer(8'h77, 1'b1, rd, ack);
    chk({7'h0, ack}, 8'h01);
    rd_chk(OFS_BUFFER, 8'h77);
    i_bfm.stop_c();
    wb_wr(OFS_STATUS, 8'h00);
    chk(8'(ev_cnt), 8'h0D);
    summarize();
  end
endmodule : tws_port_tb
